// [swc_pkg.sv]
// Purpose: shared constants and types for the sleep and watchdog controller
// Assumes: 50 MHz core clock
// Notes:   register map of the Avalon-MM slave lives here
package swc_pkg;

	// ------------------------------------------------------------
	// opcodes seen on the decode port
	// ------------------------------------------------------------
	localparam logic [7:0] OP_NOP   = 8'hff;
	localparam logic [7:0] OP_STOP  = 8'h6f;
	localparam logic [7:0] OP_HALT  = 8'h7f;
	localparam logic [7:0] OP_WATCHDOG_ENABLE_REFRESH = 8'h5f;
	localparam logic [7:0] OP_WATCHDOG_HALT_RUN       = 8'h4f;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ           = 50000000;
	localparam int WDT_TIMEOUT_MS   = 12;
	localparam int WDT_CYCLES       = (CLK_HZ / 1000) * WDT_TIMEOUT_MS;
	localparam int POR_DELAY_CYC    = 65536;
	localparam int XTAL_EXTRA_CYC   = 18;
	localparam int RST_CNT_W        = 20;
	localparam int WDT_CNT_W        = 20;

	// ------------------------------------------------------------
	// register map, byte addresses
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h4;
	localparam logic [3:0] ADDR_IRQ_ST  = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MSK = 4'hc;

	// field positions
	localparam int CTRL_PERM_BIT    = 0;
	localparam int ST_WDT_EN_BIT    = 0;
	localparam int ST_HALT_RUN_BIT  = 1;
	localparam int ST_STOP_BIT      = 2;
	localparam int ST_HALT_BIT      = 3;
	localparam int EV_WDT_TO_BIT    = 0;
	localparam int EV_STOP_REC_BIT  = 1;
	localparam int EV_LV_BIT        = 2;
	localparam int EV_W             = 3;

	// reset values
	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [EV_W-1:0] MSK_RST = 3'h0;
	localparam logic [15:0] STOP_VECTOR = 16'h000c;
	localparam logic [15:0] POR_VECTOR  = 16'h000c;

	// power state
	typedef enum logic [1:0] {PS_RUN, PS_HALT, PS_STOP} swc_pstate_t;

	// cause of the internal reset sequence
	typedef enum logic [1:0] {RC_NONE, RC_WDT, RC_LV, RC_STOP} swc_rcause_t;

	// flags presented to the core after the watchdog instruction
	typedef struct packed
	{
		logic we;
		logic z;
		logic s;
		logic v;
	} swc_flags_t;

endpackage

// [swc_rst_seq.sv]
// Purpose: times the internal reset pulse released to the core
// Assumes: start is high each cycle the main controller sees a reset cause, so a held low supply keeps it high
// Notes:   length is por delay plus extra crystal cycles, or 1 cycle for stop recovery
`timescale 1ns/1ps
module swc_rst_seq
	import swc_pkg::*;
#(
	parameter int POR_CYC = POR_DELAY_CYC
)
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic start_i,
	input  wire logic short_i,
	output logic      busy_o
);

	logic [RST_CNT_W-1:0] cnt_q;
	logic [RST_CNT_W-1:0] cnt_d;
	logic                 busy_q;
	logic                 busy_d;

	// ------------------------------------------------------------
	// count down
	// ------------------------------------------------------------
	// a fresh start restarts the count, so a second cause extends it
	always_comb
	begin
		cnt_d  = cnt_q;
		busy_d = busy_q;
		if (start_i)
		begin
			busy_d = 1'b1;
			cnt_d  = short_i ? RST_CNT_W'(1) : RST_CNT_W'(POR_CYC + XTAL_EXTRA_CYC);
		end
		else if (busy_q)
		begin
			if (cnt_q <= RST_CNT_W'(1))
				busy_d = 1'b0;
			else
				cnt_d = cnt_q - RST_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q  <= RST_CNT_W'(POR_CYC + XTAL_EXTRA_CYC); // same length as a started sequence
			busy_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
		end
	end

	assign busy_o = busy_q;

endmodule

// [swc_top.sv]
// Purpose: sleep states, watchdog and reset control of a small 8-bit core
// Assumes: core reports each executed opcode with a one-cycle strobe
// Notes:   clock gating is expressed as enables; the oscillator enable is a pin
//
// Summary of operation
// - stop instruction halts clock and oscillator
// - recovery pin low resets, restart at 000c
// - stop recovery keeps port direction register
// - recovery works even with pin as output
// - first 5f enables watchdog, later clears it
// - enabled watchdog cannot be disabled
// - missing refresh within period causes reset
// - watchdog reset equals power-on reset plus 18
// - watchdog op sets z, clears s and v
// - software watchdog pauses in stop
// - 4f lets watchdog run during halt
// - 4f ignored before watchdog enabled
// - permanent option enables watchdog, always runs
// - low supply indication resets device
// - halt stops core clock only, interrupt wakes
// - watchdog timeout at least 12 ms
`timescale 1ns/1ps
module swc_top
	import swc_pkg::*;
#(
	parameter int POR_CYC = POR_DELAY_CYC,
	parameter int WDT_CYC = WDT_CYCLES
)
(
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// core decode port
	input  wire logic        OP_STB_I,
	input  wire logic [7:0]  OP_CODE_I,
	input  wire logic        IRQ_WAKE_I,
	input  wire logic        PERM_WDT_I,
	input  wire logic        LOW_SUPPLY_I,
	input  wire logic        STOP_RECOVERY_PIN_I,
	input  wire logic [7:0]  PORT2_DIR_WR_I,
	input  wire logic        PORT2_DIR_WE_I,
	// to the core
	output logic             CPU_CLK_EN_O,
	output logic             OSC_EN_O,
	output logic             CORE_RST_O,
	output logic [15:0]      RESTART_VEC_O,
	output swc_flags_t       FLAGS_O,
	output logic [7:0]       PORT2_DIR_REG_O,
	// avalon-mm slave
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0]      AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic             IRQ_O
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [1:0] pin_sync_q;
	logic [1:0] lv_sync_q;
	logic [1:0] perm_sync_q;
	logic [1:0] wake_sync_q;

	// first stage read only by the second
	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			pin_sync_q  <= 2'h3;
			lv_sync_q   <= 2'h0;
			perm_sync_q <= 2'h0;
			wake_sync_q <= 2'h0;
		end
		else
		begin
			pin_sync_q  <= {pin_sync_q[0], STOP_RECOVERY_PIN_I};
			lv_sync_q   <= {lv_sync_q[0], LOW_SUPPLY_I};
			perm_sync_q <= {perm_sync_q[0], PERM_WDT_I};
			wake_sync_q <= {wake_sync_q[0], IRQ_WAKE_I};
		end
	end

	wire pin_low   = ~pin_sync_q[1];
	wire low_sup   = lv_sync_q[1];
	wire perm_opt  = perm_sync_q[1];
	wire irq_wake  = wake_sync_q[1];

	// ------------------------------------------------------------
	// internal reset sequencer
	// ------------------------------------------------------------
	logic        seq_start;
	logic        seq_short;
	logic        seq_busy;

	swc_rst_seq #(
		.POR_CYC (POR_CYC)
	) u_seq (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.start_i (seq_start),
		.short_i (seq_short),
		.busy_o  (seq_busy)
	);

	// ------------------------------------------------------------
	// power state, watchdog and restart state
	// ------------------------------------------------------------
	swc_pstate_t          ps_q, ps_d;
	swc_rcause_t          cause_q, cause_d;
	logic                 wdt_en_q, wdt_en_d;
	logic                 halt_run_q, halt_run_d;
	logic [WDT_CNT_W-1:0] wdt_cnt_q, wdt_cnt_d;
	logic                 perm_q, perm_d;
	logic [7:0]           p2dir_q, p2dir_d;
	logic [15:0]          vec_q, vec_d;
	swc_flags_t           flags_q, flags_d;
	logic                 busy_prev_q;

	logic wdt_run;
	logic wdt_expire;
	logic op_exec;

	// core executes only while running and not held in reset
	assign op_exec = OP_STB_I && (ps_q == PS_RUN) && !seq_busy;

	// counting is allowed per sleep state and option
	always_comb
	begin
		case (ps_q)
			PS_RUN:  wdt_run = wdt_en_q;
			PS_HALT: wdt_run = wdt_en_q && (halt_run_q || perm_q);
			PS_STOP: wdt_run = wdt_en_q && perm_q;
			default: wdt_run = 1'b0;
		endcase
	end

	// compare one below the period, the counter starts from zero
	assign wdt_expire = wdt_run && (wdt_cnt_q >= WDT_CNT_W'(WDT_CYC - 1));

	// next state of the controller
	always_comb
	begin
		ps_d       = ps_q;
		cause_d    = RC_NONE;
		wdt_en_d   = wdt_en_q;
		halt_run_d = halt_run_q;
		wdt_cnt_d  = wdt_cnt_q;
		perm_d     = perm_q;
		p2dir_d    = p2dir_q;
		vec_d      = vec_q;
		flags_d    = flags_q;
		flags_d.we = 1'b0;
		seq_start  = 1'b0;
		seq_short  = 1'b0;

		if (seq_busy)
		begin
			// held in reset: option is sampled, not the port
			perm_d = perm_opt;
		end
		else if (busy_prev_q)
		begin
			// release edge of the internal reset
			wdt_en_d = perm_q;
		end

		if (PORT2_DIR_WE_I && !seq_busy)
			p2dir_d = PORT2_DIR_WR_I;

		// count first, so a refresh below overrides the increment
		if (wdt_run)
			wdt_cnt_d = wdt_expire ? '0 : wdt_cnt_q + WDT_CNT_W'(1);

		if (op_exec)
		begin
			case (OP_CODE_I)
				OP_STOP: ps_d = PS_STOP;
				OP_HALT: ps_d = PS_HALT;
				OP_WATCHDOG_ENABLE_REFRESH:
				begin
					if (wdt_en_q)
						wdt_cnt_d = '0;
					wdt_en_d = 1'b1;
					flags_d  = '{we: 1'b1, z: 1'b1, s: 1'b0, v: 1'b0};
				end
				OP_WATCHDOG_HALT_RUN:
				begin
					if (wdt_en_q)
						halt_run_d = 1'b1;
				end
				default: ;
			endcase
		end

		// interrupt wakes from halt, core resumes after the instruction
		if (ps_q == PS_HALT && irq_wake)
			ps_d = PS_RUN;


		// reset causes, low supply first
		if (low_sup)
		begin
			cause_d = RC_LV;
		end
		else if (wdt_expire)
		begin
			cause_d = RC_WDT;
		end
		else if (ps_q == PS_STOP && pin_low)
		begin
			cause_d = RC_STOP;
		end

		if (cause_d != RC_NONE)
		begin
			seq_start  = 1'b1;
			seq_short  = (cause_d == RC_STOP);
			ps_d       = PS_RUN;
			wdt_cnt_d  = '0;
			wdt_en_d   = 1'b0;
			halt_run_d = 1'b0;
			vec_d      = (cause_d == RC_STOP) ? STOP_VECTOR : POR_VECTOR;
			if (cause_d != RC_STOP)
				p2dir_d = 8'h00;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ps_q        <= PS_RUN;
			cause_q     <= RC_NONE;
			wdt_en_q    <= 1'b0;
			halt_run_q  <= 1'b0;
			wdt_cnt_q   <= '0;
			perm_q      <= 1'b0;
			p2dir_q     <= 8'h00;
			vec_q       <= POR_VECTOR;
			flags_q     <= '0;
			busy_prev_q <= 1'b1;
		end
		else
		begin
			ps_q        <= ps_d;
			cause_q     <= cause_d;
			wdt_en_q    <= wdt_en_d;
			halt_run_q  <= halt_run_d;
			wdt_cnt_q   <= wdt_cnt_d;
			perm_q      <= perm_d;
			p2dir_q     <= p2dir_d;
			vec_q       <= vec_d;
			flags_q     <= flags_d;
			busy_prev_q <= seq_busy;
		end
	end

	// ------------------------------------------------------------
	// core side outputs
	// ------------------------------------------------------------
	// gating as enables keeps the design on one clock
	assign CPU_CLK_EN_O    = (ps_q == PS_RUN) && !seq_busy;
	assign OSC_EN_O        = (ps_q != PS_STOP);
	assign CORE_RST_O      = seq_busy;
	assign RESTART_VEC_O   = vec_q;
	assign FLAGS_O         = flags_q;
	assign PORT2_DIR_REG_O = p2dir_q;

	// ------------------------------------------------------------
	// interrupt status and register bus
	// ------------------------------------------------------------
	logic [EV_W-1:0]  ev_st_q, ev_st_d;
	logic [EV_W-1:0]  ev_msk_q, ev_msk_d;
	logic [31:0]      rdata_q, rdata_d;
	logic             ack_q, ack_d;
	logic [EV_W-1:0]  ev_set;

	assign ev_set = {cause_q == RC_LV, cause_q == RC_STOP, cause_q == RC_WDT};

	// one wait state; a new event wins over a clear in the same cycle
	always_comb
	begin
		ev_st_d  = ev_st_q;
		ev_msk_d = ev_msk_q;
		rdata_d  = rdata_q;
		ack_d    = 1'b0;
		if ((AVS_READ || AVS_WRITE) && !ack_q)
		begin
			ack_d = 1'b1;
			if (AVS_WRITE)
			begin
				if (AVS_ADDRESS == ADDR_IRQ_ST)
					ev_st_d = ev_st_q & ~AVS_WRITEDATA[EV_W-1:0];
				else if (AVS_ADDRESS == ADDR_IRQ_MSK)
					ev_msk_d = AVS_WRITEDATA[EV_W-1:0];
			end
			else
			begin
				if (AVS_ADDRESS == ADDR_CTRL)
					rdata_d = {31'h0, perm_q};
				else if (AVS_ADDRESS == ADDR_STATUS)
					rdata_d = {28'h0, ps_q == PS_HALT, ps_q == PS_STOP, halt_run_q, wdt_en_q};
				else if (AVS_ADDRESS == ADDR_IRQ_ST)
					rdata_d = {29'h0, ev_st_q};
				else if (AVS_ADDRESS == ADDR_IRQ_MSK)
					rdata_d = {29'h0, ev_msk_q};
				else
					rdata_d = 32'h0000_0000;
			end
		end
		ev_st_d = ev_st_d | ev_set;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ev_st_q  <= '0;
			ev_msk_q <= MSK_RST;
			rdata_q  <= 32'h0000_0000;
			ack_q    <= 1'b0;
		end
		else
		begin
			ev_st_q  <= ev_st_d;
			ev_msk_q <= ev_msk_d;
			rdata_q  <= rdata_d;
			ack_q    <= ack_d;
		end
	end

	// waitrequest drops once the answer sits in the registers
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
	assign AVS_READDATA    = rdata_q;
	assign IRQ_O           = |(ev_st_q & ev_msk_q);

endmodule

// [swc_sva.sv]
// Purpose: port assertions for the sleep and watchdog controller
// Assumes: one clock, async reset RST_I
// Notes:   reset length is measured by a small counter
`timescale 1ns/1ps
module swc_sva
	import swc_pkg::*;
#(
	parameter int POR_CYC = POR_DELAY_CYC
)
(
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        OP_STB_I,
	input wire logic [7:0]  OP_CODE_I,
	input wire logic        IRQ_WAKE_I,
	input wire logic        LOW_SUPPLY_I,
	input wire logic        STOP_RECOVERY_PIN_I,
	input wire logic        CPU_CLK_EN_O,
	input wire logic        OSC_EN_O,
	input wire logic        CORE_RST_O,
	input wire logic [15:0] RESTART_VEC_O,
	input wire swc_flags_t  FLAGS_O,
	input wire logic [7:0]  PORT2_DIR_REG_O
);
	logic [RST_CNT_W-1:0] rcnt_q;
	logic [RST_CNT_W-1:0] rcnt_d;
	logic [1:0]           lv_q;

	// cycles of the current core reset; a held low supply restarts it
	always_comb
	begin
		rcnt_d = (CORE_RST_O && !lv_q[1]) ? rcnt_q + RST_CNT_W'(1) : '0;
	end

	always_ff @(posedge CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			rcnt_q <= '0;
			lv_q   <= 2'h0;
		end
		else
		begin
			rcnt_q <= rcnt_d;
			lv_q   <= {lv_q[0], LOW_SUPPLY_I};
		end
	end

	// --------
	// checks
	// --------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RST_I);

	AST_STOP_OSC: assert property (OP_STB_I && CPU_CLK_EN_O && OP_CODE_I == OP_STOP
		|=> !OSC_EN_O) else $error("oscillator not stopped");
	AST_STOP_CLK: assert property (!OSC_EN_O |-> !CPU_CLK_EN_O)
		else $error("core clock runs in stop");
	AST_WDT_FLAGS: assert property (OP_STB_I && CPU_CLK_EN_O && OP_CODE_I == OP_WATCHDOG_ENABLE_REFRESH
		|=> FLAGS_O.we && FLAGS_O.z && !FLAGS_O.s && !FLAGS_O.v) else $error("flags wrong");
	AST_VECTOR: assert property (RESTART_VEC_O == 16'h000c)
		else $error("restart vector wrong");
	AST_LOW_RST: assert property (LOW_SUPPLY_I |-> ##[0:3] CORE_RST_O)
		else $error("no reset on low supply");
	AST_RECOVER: assert property ((!OSC_EN_O && !STOP_RECOVERY_PIN_I) [*3]
		|-> ##[0:3] CORE_RST_O) else $error("no stop recovery");
	AST_P2_KEEP: assert property (!OSC_EN_O && !STOP_RECOVERY_PIN_I
		|=> $stable(PORT2_DIR_REG_O)) else $error("direction lost in recovery");
	AST_RST_LEN: assert property ($fell(CORE_RST_O) |-> rcnt_q <= RST_CNT_W'(3)
		|| (rcnt_q >= POR_CYC + XTAL_EXTRA_CYC && rcnt_q <= POR_CYC + XTAL_EXTRA_CYC + 2))
		else $error("reset length wrong");
	AST_WAKE: assert property ((!CORE_RST_O && OSC_EN_O && IRQ_WAKE_I) [*4]
		|-> CPU_CLK_EN_O) else $error("no wake from halt");
endmodule

bind swc_top swc_sva #(.POR_CYC(POR_CYC)) u_sva
(
	.CLK_I, .RST_I, .OP_STB_I, .OP_CODE_I, .IRQ_WAKE_I, .LOW_SUPPLY_I,
	.STOP_RECOVERY_PIN_I, .CPU_CLK_EN_O, .OSC_EN_O, .CORE_RST_O,
	.RESTART_VEC_O, .FLAGS_O, .PORT2_DIR_REG_O
);

// [swc_core_model.sv]
// Purpose: core side that executes opcodes and writes port 2 direction
// Assumes: opcodes only count while the core clock runs
// Notes:   opcode bus shows a changed value once the strobe drops
`timescale 1ns/1ps
module swc_core_model
	import swc_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  clk_en_i,
	output logic       op_stb_o,
	output logic [7:0] op_code_o,
	output logic [7:0] dir_o,
	output logic       dir_we_o
);
	logic stall_q = 1'b0; // set when an opcode waited in vain for the core clock
	initial
	begin
		op_stb_o = 1'b0;
		op_code_o = 8'h00;
		dir_o = 8'h00;
		dir_we_o = 1'b0;
	end

	// one opcode; waits for a running core clock
	task automatic exec(input logic [7:0] op);
		int n;
		n = 0;
		do
		begin
			@(negedge clk_i);
			n++;
		end
		while (!clk_en_i && n < 200);
		if (!clk_en_i)
			stall_q = 1'b1;
		@(posedge clk_i);
		op_stb_o <= 1'b1;
		op_code_o <= op;
		@(posedge clk_i);
		op_stb_o <= 1'b0;
		op_code_o <= ~op;
	endtask

	// no-op first so no instruction is cut in half
	task automatic sleep(input logic [7:0] op);
		exec(OP_NOP);
		exec(op);
	endtask

	// direction write; bit 7 set makes the recovery pin an input
	task automatic dir(input logic [7:0] v);
		@(posedge clk_i);
		dir_o <= v;
		dir_we_o <= 1'b1;
		@(posedge clk_i);
		dir_we_o <= 1'b0;
	endtask
endmodule

// [swc_top_tb.sv]
// Purpose: self-checking bench for swc_top
// Assumes: short reset and watchdog counts through parameters
// Notes:   bus reads are checked by a watcher process from a queue
`timescale 1ns/1ps
module swc_top_tb import swc_pkg::*;;
	localparam int WC = 50;
	logic CLK_I, RST_I, OP_STB_I, IRQ_WAKE_I, PERM_WDT_I, LOW_SUPPLY_I;
	logic STOP_RECOVERY_PIN_I, PORT2_DIR_WE_I, AVS_READ, AVS_WRITE, IRQ_O;
	logic CPU_CLK_EN_O, OSC_EN_O, CORE_RST_O, AVS_WAITREQUEST, rprev;
	logic [7:0] OP_CODE_I, PORT2_DIR_WR_I, PORT2_DIR_REG_O, d;
	logic [3:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA;
	logic [15:0] RESTART_VEC_O;
	swc_flags_t FLAGS_O;
	logic [31:0] expq[$];
	int mismatches, check_count, nrst, n0;

	swc_top #(.POR_CYC(8), .WDT_CYC(WC)) dut
	(
		.CLK_I, .RST_I, .OP_STB_I, .OP_CODE_I, .IRQ_WAKE_I, .PERM_WDT_I, .LOW_SUPPLY_I,
		.STOP_RECOVERY_PIN_I, .PORT2_DIR_WR_I, .PORT2_DIR_WE_I, .CPU_CLK_EN_O, .OSC_EN_O,
		.CORE_RST_O, .RESTART_VEC_O, .FLAGS_O, .PORT2_DIR_REG_O, .AVS_ADDRESS, .AVS_READ,
		.AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .IRQ_O
	);
	swc_core_model core
	(
		.clk_i(CLK_I), .clk_en_i(CPU_CLK_EN_O), .op_stb_o(OP_STB_I),
		.op_code_o(OP_CODE_I), .dir_o(PORT2_DIR_WR_I), .dir_we_o(PORT2_DIR_WE_I)
	);

	// --------
	// helpers
	// --------
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask

	// bounded wait for a core reset level
	task wfor(input logic v, input int n);
		int k;
		k = 0;
		do
		begin
			@(negedge CLK_I);
			k++;
		end
		while (CORE_RST_O !== v && k < n);
		if (CORE_RST_O !== v)
		begin
			$display("ERROR core reset expected %b seen %b", v, CORE_RST_O);
			mismatches++;
			wrap_up;
		end
	endtask

	// one bus cycle, held until waitrequest is seen low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] dt);
		int k;
		k = 0;
		@(posedge CLK_I);
		AVS_READ <= !w;
		AVS_WRITE <= w;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= dt;
		do
		begin
			@(negedge CLK_I);
			k++;
		end
		while (AVS_WAITREQUEST !== 1'b0 && k < 20);
		if (AVS_WAITREQUEST !== 1'b0)
		begin
			$display("ERROR waitrequest expected 0 seen %b", AVS_WAITREQUEST);
			mismatches++;
			wrap_up;
		end
		@(posedge CLK_I);
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	task wr(input logic [3:0] a, input logic [31:0] dt);
		bus(1'b1, a, dt);
	endtask

	// watcher: read data against the oldest note, count reset entries
	always @(negedge CLK_I)
	begin
		if (AVS_READ && AVS_WAITREQUEST === 1'b0 && expq.size() > 0)
			chk("readdata", expq.pop_front(), AVS_READDATA);
		if (CORE_RST_O === 1'b1 && !rprev)
			nrst++;
		rprev = CORE_RST_O;
	end

	initial
	begin
		CLK_I = 1'b0;
		forever #10 CLK_I = ~CLK_I;
	end

	// hang guard
	initial
	begin
		repeat (20000) @(posedge CLK_I);
		$display("ERROR run expected end seen timeout");
		mismatches++;
		wrap_up;
	end

	initial
	begin
		{RST_I, rprev, STOP_RECOVERY_PIN_I} = 3'h7;
		{IRQ_WAKE_I, PERM_WDT_I, LOW_SUPPLY_I, AVS_READ, AVS_WRITE} = 5'h00;
		AVS_ADDRESS = 4'h0;
		AVS_WRITEDATA = 32'h0;
		void'($urandom(31924));
		repeat (3) @(posedge CLK_I);
		RST_I <= 1'b0;
		wfor(1'b0, 60);
		@(negedge CLK_I) chk("vector", 32'h000c, 32'(RESTART_VEC_O));
		rd(ADDR_STATUS, 32'h0);
		rd(4'h2, 32'h0);
		core.exec(OP_WATCHDOG_HALT_RUN);
		rd(ADDR_STATUS, 32'h0);
		core.exec(OP_WATCHDOG_ENABLE_REFRESH);
		rd(ADDR_STATUS, 32'h1);
		core.exec(OP_WATCHDOG_HALT_RUN);
		rd(ADDR_STATUS, 32'h3);
		n0 = nrst;
		repeat (5)
		begin
			repeat (WC - 15) @(posedge CLK_I);
			core.exec(OP_WATCHDOG_ENABLE_REFRESH);
		end
		chk("resets", 32'(n0), 32'(nrst));
		$display("test enable done");
		// halt-run lets the timeout happen while halted
		core.sleep(OP_HALT);
		wfor(1'b1, WC + 10);
		wfor(1'b0, 60);
		@(negedge CLK_I) chk("irq", 32'h0, 32'(IRQ_O));
		rd(ADDR_IRQ_ST, 32'h1);
		wr(ADDR_IRQ_MSK, 32'h1);
		@(negedge CLK_I) chk("irq", 32'h1, 32'(IRQ_O));
		rd(ADDR_IRQ_MSK, 32'h1);
		wr(ADDR_IRQ_ST, 32'h1);
		@(negedge CLK_I) chk("irq", 32'h0, 32'(IRQ_O));
		rd(ADDR_STATUS, 32'h0);
		$display("test timeout done");
		// stop with the pin as input, then as output
		for (int i = 0; i < 2; i++)
		begin
			d = {~i[0], 7'($urandom)};
			core.dir(d);
			core.exec(OP_WATCHDOG_ENABLE_REFRESH);
			n0 = nrst;
			core.sleep(OP_STOP);
			rd(ADDR_STATUS, 32'h5);
			repeat (2 * WC) @(posedge CLK_I);
			STOP_RECOVERY_PIN_I <= 1'b0;
			@(negedge CLK_I) chk("osc", 32'h0, 32'(OSC_EN_O));
			chk("resets", 32'(n0), 32'(nrst));
			wfor(1'b1, 8);
			@(posedge CLK_I);
			STOP_RECOVERY_PIN_I <= 1'b1;
			wfor(1'b0, 60);
			@(negedge CLK_I) chk("port2", 32'(d), 32'(PORT2_DIR_REG_O));
			rd(ADDR_IRQ_ST, 32'h2);
			wr(ADDR_IRQ_ST, 32'h7);
		end
		$display("test stop done");
		@(posedge CLK_I);
		LOW_SUPPLY_I <= 1'b1;
		wfor(1'b1, 5);
		@(posedge CLK_I);
		LOW_SUPPLY_I <= 1'b0;
		wfor(1'b0, 60);
		@(negedge CLK_I) chk("port2", 32'h0, 32'(PORT2_DIR_REG_O));
		rd(ADDR_IRQ_ST, 32'h4);
		// plain halt pauses the watchdog
		core.exec(OP_WATCHDOG_ENABLE_REFRESH);
		n0 = nrst;
		core.sleep(OP_HALT);
		rd(ADDR_STATUS, 32'h9);
		repeat (3 * WC) @(posedge CLK_I);
		IRQ_WAKE_I <= 1'b1;
		chk("resets", 32'(n0), 32'(nrst));
		repeat (4) @(posedge CLK_I);
		IRQ_WAKE_I <= 1'b0;
		@(negedge CLK_I) chk("clk en", 32'h1, 32'(CPU_CLK_EN_O));
		$display("test halt done");
		@(posedge CLK_I);
		PERM_WDT_I <= 1'b1;
		RST_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
		RST_I <= 1'b0;
		wfor(1'b0, 60);
		rd(ADDR_CTRL, 32'h1);
		rd(ADDR_STATUS, 32'h1);
		core.sleep(OP_STOP);
		wfor(1'b1, WC + 10);
		chk("core stall", 32'h0, 32'(core.stall_q));
		$display("test permanent done");
		wrap_up;
	end
endmodule
